// File: logic/flk_defs.svh
// Bit positions, reset values and timing counts for the flash lock, status and
// read configuration logic. Definitions only; included by the design.
`ifndef FLK_DEFS_SVH
`define FLK_DEFS_SVH

// Operation status word
`define FLK_ST_READY      7
`define FLK_ST_ERS_SUSP   6
`define FLK_ST_ERS_ERR    5
`define FLK_ST_PRG_ERR    4
`define FLK_ST_SUPPLY     3
`define FLK_ST_PRG_SUSP   2
`define FLK_ST_PROTECT    1
`define FLK_ST_OTHER      0
// Page buffer availability word
`define FLK_XS_AVAIL      7
// Read configuration fields
`define FLK_RC_MODE       15
`define FLK_RC_LAT_HI     13
`define FLK_RC_LAT_LO     11
`define FLK_RC_WAIT_POL   10
`define FLK_RC_HOLD       9
`define FLK_RC_ORDER      7
`define FLK_RC_EDGE       6
`define FLK_RC_WRAP       3
`define FLK_RC_LEN_HI     2
`define FLK_RC_LEN_LO     0
`define FLK_RC_RESET      16'hFFFF
// Burst length codes
`define FLK_LEN_4         3'h1
`define FLK_LEN_8         3'h2
// Write engine busy time in clocks
`define FLK_OP_CYCLES     16

`endif

// File: logic/flk_pkg.sv
// Types shared by the flash lock, status and read configuration logic.
// Assumes the constants header is compiled alongside.
package flk_pkg;
  typedef enum logic [2:0] {
    FLK_CMD_NONE     = 3'h0,
    FLK_CMD_SET_LOCK = 3'h1,
    FLK_CMD_CLR_LOCK = 3'h2,
    FLK_CMD_SET_LDN  = 3'h3,
    FLK_CMD_SET_RCFG = 3'h4,
    FLK_CMD_CLR_STAT = 3'h5
  } flk_cmd_t;
  typedef enum logic [1:0] {
    FLK_OP_ERASE   = 2'h0,
    FLK_OP_PROGRAM = 2'h1,
    FLK_OP_FACTORY = 2'h2,
    FLK_OP_OTP     = 2'h3
  } flk_op_t;
  typedef enum logic [1:0] {
    FLK_BU_IDLE = 2'h0,
    FLK_BU_LAT  = 2'h1,
    FLK_BU_DATA = 2'h3
  } flk_burst_t;
endpackage

// File: logic/flk_core.sv
// Block lock state, write engine status and read configuration with burst
// address sequencing. Assumes a host that issues decoded commands, one-cycle
// operation starts and burst requests, all synchronous to i_clock.
`timescale 1ns/1ps
`include "flk_defs.svh"

module flk_core #(
  parameter int BLOCKS    = 8,
  parameter int BLK_W     = 3,
  parameter int ADDR_W    = 22,
  parameter int OP_CYCLES = `FLK_OP_CYCLES
) (
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  input  wire logic              i_write_protect_n,
  input  wire logic              i_cmd_valid,
  input  wire flk_pkg::flk_cmd_t i_cmd_code,
  input  wire logic [BLK_W-1:0]  i_cmd_block,
  input  wire logic [15:0]       i_cmd_data,
  input  wire logic              i_op_start,
  input  wire flk_pkg::flk_op_t  i_op_kind,
  input  wire logic [BLK_W-1:0]  i_op_block,
  input  wire logic              i_supply_ok,
  input  wire logic              i_erase_suspend,
  input  wire logic              i_program_suspend,
  input  wire logic              i_other_busy,
  input  wire logic              i_factory_mode,
  input  wire logic [BLK_W-1:0]  i_id_block,
  input  wire logic              i_burst_start,
  input  wire logic              i_burst_stop,
  input  wire logic [ADDR_W-1:0] i_burst_addr,
  output logic [15:0]            o_status,
  output logic [15:0]            o_buffer_status,
  output logic [15:0]            o_read_config,
  output logic [1:0]             o_lock_flags,
  output logic [ADDR_W-1:0]      o_burst_addr,
  output logic                   o_burst_valid,
  output logic                   o_wait
);

  // ****************************************************************
  // Protect pin edges and per-block lock state
  // ****************************************************************
  logic              wp_q;
  logic              wp_rise;
  logic              wp_fall;
  logic [BLOCKS-1:0] block_locked_flag;
  logic [BLOCKS-1:0] block_lockdown_flag;
  logic [BLOCKS-1:0] from_open;

  // Reset value 0 only makes a harmless rise, which touches no lock bit
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_q <= 1'b0;
    end else begin
      wp_q <= i_write_protect_n;
    end
  end
  assign wp_rise = i_write_protect_n & ~wp_q;
  assign wp_fall = ~i_write_protect_n & wp_q;

  genvar gb;
  generate
    for (gb = 0; gb < BLOCKS; gb++) begin : g_blk
      logic hit;
      // Only lock commands pre-empt a protect edge; other codes must not swallow one
      assign hit = i_cmd_valid && (i_cmd_block == BLK_W'(gb)) &&
                   (i_cmd_code == flk_pkg::FLK_CMD_SET_LOCK ||
                    i_cmd_code == flk_pkg::FLK_CMD_CLR_LOCK ||
                    i_cmd_code == flk_pkg::FLK_CMD_SET_LDN);
      // Lock commands take priority; protect edges act only without a lock command to the block
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          block_locked_flag[gb]   <= 1'b1;
          block_lockdown_flag[gb] <= 1'b0;
          from_open[gb]           <= 1'b0;
        end else if (hit) begin
          case (i_cmd_code)
            flk_pkg::FLK_CMD_SET_LOCK: begin
              block_locked_flag[gb] <= 1'b1;
            end
            flk_pkg::FLK_CMD_CLR_LOCK: begin
              if (i_write_protect_n || !block_lockdown_flag[gb]) begin
                block_locked_flag[gb] <= 1'b0;
              end
            end
            flk_pkg::FLK_CMD_SET_LDN: begin
              block_locked_flag[gb]   <= 1'b1;
              block_lockdown_flag[gb] <= 1'b1;
            end
            default: begin
            end
          endcase
        end else if (wp_fall && block_lockdown_flag[gb]) begin
          // Remember whether the block was open before the lock-down took hold
          from_open[gb]         <= ~block_locked_flag[gb];
          block_locked_flag[gb] <= 1'b1;
        end else if (wp_rise && block_lockdown_flag[gb]) begin
          block_locked_flag[gb] <= ~from_open[gb];
        end
      end
    end
  endgenerate

  // Lock flags read back per block, bit 1 lock-down, bit 0 lock
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_lock_flags <= 2'h0;
    end else begin
      o_lock_flags <= {block_lockdown_flag[i_id_block], block_locked_flag[i_id_block]};
    end
  end

  // ****************************************************************
  // Write engine and status flags
  // ****************************************************************
  logic        busy;
  logic [15:0] op_count;
  logic        op_go;
  logic        op_refuse;
  logic        clr_stat;
  logic        erase_error_flag;
  logic        program_error_flag;
  logic        supply_low_flag;
  logic        protect_abort_flag;

  assign op_go     = i_op_start && !busy;
  assign op_refuse = !i_supply_ok ||
                     (block_locked_flag[i_op_block] && i_op_kind != flk_pkg::FLK_OP_OTP);
  assign clr_stat  = i_cmd_valid && i_cmd_code == flk_pkg::FLK_CMD_CLR_STAT;

  // Busy only for accepted operations; refused ones abort at once
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      busy     <= 1'b0;
      op_count <= 16'h0000;
    end else if (op_go && !op_refuse) begin
      busy     <= 1'b1;
      op_count <= 16'(OP_CYCLES - 1);
    end else if (busy) begin
      op_count <= op_count - 16'h0001;
      busy     <= (op_count != 16'h0000);
    end
  end

  // Sticky flags: a fresh abort beats a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      supply_low_flag    <= 1'b0;
      protect_abort_flag <= 1'b0;
      erase_error_flag   <= 1'b0;
      program_error_flag <= 1'b0;
    end else if (op_go) begin
      supply_low_flag    <= !i_supply_ok || (supply_low_flag && !clr_stat);
      protect_abort_flag <= (i_supply_ok && op_refuse) ||
                            (protect_abort_flag && !clr_stat);
      if (i_op_kind == flk_pkg::FLK_OP_ERASE) begin
        erase_error_flag <= op_refuse || (erase_error_flag && !clr_stat);
      end else begin
        erase_error_flag <= erase_error_flag && !clr_stat;
      end
      if (i_op_kind != flk_pkg::FLK_OP_ERASE) begin
        program_error_flag <= op_refuse || (program_error_flag && !clr_stat);
      end else begin
        program_error_flag <= program_error_flag && !clr_stat;
      end
    end else if (clr_stat) begin
      supply_low_flag    <= 1'b0;
      protect_abort_flag <= 1'b0;
      erase_error_flag   <= 1'b0;
      program_error_flag <= 1'b0;
    end
  end

  // Status words; upper byte reserved and zero so masking is harmless
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_status        <= 16'h0080;
      o_buffer_status <= 16'h0080;
    end else begin
      o_status <= 16'h0000;
      if (i_factory_mode) begin
        o_status[`FLK_ST_READY] <= 1'b0;
        o_status[`FLK_ST_OTHER] <= busy;
      end else begin
        o_status[`FLK_ST_READY] <= !busy && !i_other_busy;
        o_status[`FLK_ST_OTHER] <= !busy && i_other_busy;
      end
      o_status[`FLK_ST_ERS_SUSP] <= i_erase_suspend;
      o_status[`FLK_ST_ERS_ERR]  <= erase_error_flag;
      o_status[`FLK_ST_PRG_ERR]  <= program_error_flag;
      o_status[`FLK_ST_SUPPLY]   <= supply_low_flag;
      o_status[`FLK_ST_PRG_SUSP] <= i_program_suspend;
      o_status[`FLK_ST_PROTECT]  <= protect_abort_flag;
      o_buffer_status <= 16'h0000;
      o_buffer_status[`FLK_XS_AVAIL] <= !busy;
    end
  end

  // ****************************************************************
  // Read configuration and burst sequencing
  // ****************************************************************
  flk_pkg::flk_burst_t burst_state;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] idx;
  logic [ADDR_W-1:0] len_mask;
  logic [ADDR_W-1:0] next_addr;
  logic [2:0]        lat_count;
  logic              hold_phase;
  logic              read_mode_select;
  logic [2:0]        latency_code;
  logic [2:0]        burst_length_code;
  logic              continuous;

  // Reset to all ones, i.e. asynchronous reads
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_read_config <= `FLK_RC_RESET;
    end else if (i_cmd_valid && i_cmd_code == flk_pkg::FLK_CMD_SET_RCFG) begin
      o_read_config <= i_cmd_data;
    end
  end

  assign read_mode_select  = o_read_config[`FLK_RC_MODE];
  assign latency_code      = o_read_config[`FLK_RC_LAT_HI:`FLK_RC_LAT_LO];
  assign burst_length_code = o_read_config[`FLK_RC_LEN_HI:`FLK_RC_LEN_LO];
  // Reserved length codes run as continuous so the burst never stalls
  assign continuous = burst_length_code != `FLK_LEN_4 && burst_length_code != `FLK_LEN_8;
  assign len_mask   = (burst_length_code == `FLK_LEN_4) ? ADDR_W'(3) : ADDR_W'(7);

  // Word address from start and index under order and wrap settings
  always_comb begin
    next_addr = start_addr + idx;
    if (!continuous && !o_read_config[`FLK_RC_ORDER]) begin
      next_addr = (start_addr & ~len_mask) | ((start_addr ^ idx) & len_mask);
    end else if (!continuous && !o_read_config[`FLK_RC_WRAP]) begin
      next_addr = (start_addr & ~len_mask) | ((start_addr + idx) & len_mask);
    end
  end

  // Latency counts the field code in clocks; an async switch aborts the burst
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      burst_state <= flk_pkg::FLK_BU_IDLE;
      start_addr  <= '0;
      idx         <= '0;
      lat_count   <= 3'h0;
      hold_phase  <= 1'b0;
    end else if (read_mode_select || i_burst_stop) begin
      burst_state <= flk_pkg::FLK_BU_IDLE;
    end else if (i_burst_start) begin
      burst_state <= flk_pkg::FLK_BU_LAT;
      start_addr  <= i_burst_addr;
      idx         <= '0;
      lat_count   <= latency_code;
      hold_phase  <= 1'b0;
    end else begin
      case (burst_state)
        flk_pkg::FLK_BU_LAT: begin
          lat_count <= lat_count - 3'h1;
          if (lat_count <= 3'h1) begin
            burst_state <= flk_pkg::FLK_BU_DATA;
          end
        end
        flk_pkg::FLK_BU_DATA: begin
          // Two-clock hold advances on every other clock
          hold_phase <= o_read_config[`FLK_RC_HOLD] && !hold_phase;
          if (!o_read_config[`FLK_RC_HOLD] || hold_phase) begin
            idx <= idx + ADDR_W'(1);
            if (!continuous && idx == len_mask) begin
              burst_state <= flk_pkg::FLK_BU_IDLE;
            end
          end
        end
        default: begin
          burst_state <= flk_pkg::FLK_BU_IDLE;
        end
      endcase
    end
  end

  // Edge select is carried in the register for the pad stage, which picks
  // the launching edge; this core presents data once per i_clock.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_burst_addr  <= '0;
      o_burst_valid <= 1'b0;
      o_wait        <= 1'b0;
    end else begin
      o_burst_addr  <= next_addr;
      o_burst_valid <= !read_mode_select && burst_state == flk_pkg::FLK_BU_DATA;
      // Asserted level during latency, idle level otherwise
      o_wait <= (!read_mode_select && burst_state == flk_pkg::FLK_BU_LAT) ==
                o_read_config[`FLK_RC_WAIT_POL];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic up_q;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  reset_lock_a: assert property (!up_q |-> block_locked_flag[0] && !block_lockdown_flag[0])
    else $error("block not locked after reset");
  locked_refuse_a: assert property (op_go && op_refuse
    |=> !busy && (supply_low_flag || protect_abort_flag))
    else $error("operation on locked block started");
  wp_fall_a: assert property (wp_fall && !i_cmd_valid && block_lockdown_flag[0]
    && !block_locked_flag[0] |=> block_locked_flag[0] ##1 from_open[0] || !up_q)
    else $error("protect fall did not relock");
  ldown_cmd_a: assert property (i_cmd_valid && i_cmd_block == '0
    && i_cmd_code == flk_pkg::FLK_CMD_SET_LDN |=> block_locked_flag[0]
    && block_lockdown_flag[0])
    else $error("lock-down command failed");
  set_lock_a: assert property (i_cmd_valid && i_cmd_block == '0
    && i_cmd_code == flk_pkg::FLK_CMD_SET_LOCK |=> block_locked_flag[0])
    else $error("set lock failed");
  part_code_a: assert property (!(o_status[7] && o_status[0]))
    else $error("status code 11 seen");
  supply_hold_a: assert property (!op_go && !clr_stat |=> $stable(supply_low_flag))
    else $error("supply flag moved without sampling");
  async_idle_a: assert property (read_mode_select |=> !o_burst_valid ##1 !o_burst_valid)
    else $error("burst output in asynchronous mode");
  // Busy length follows OP_CYCLES, so check the loaded count and the release point
  busy_time_a: assert property (op_go && !op_refuse
    |=> busy && op_count == 16'(OP_CYCLES - 1))
    else $error("write engine ended early");
  busy_end_a: assert property (busy && op_count == 16'h0000 |=> !busy)
    else $error("write engine overran its count");

  burst_cov_c: cover property (o_burst_valid ##1 o_burst_valid);
  refuse_cov_c: cover property (op_go && op_refuse);
  wp_rise_cov_c: cover property (wp_rise && block_lockdown_flag[0]);

endmodule // flk_core

// File: dv/flk_host.sv
// Host controller model: decoded commands, operation starts and burst requests.
// Assumes the clock of the flash control block; requests change 1 ns after an edge.
`timescale 1ns/1ps

module flk_host #(
  parameter int BLK_W  = 3,
  parameter int ADDR_W = 22
) (
  input  wire logic         i_clock,
  output logic              o_cmd_valid,
  output flk_pkg::flk_cmd_t o_cmd_code,
  output logic [BLK_W-1:0]  o_cmd_block,
  output logic [15:0]       o_cmd_data,
  output logic              o_op_start,
  output flk_pkg::flk_op_t  o_op_kind,
  output logic [BLK_W-1:0]  o_op_block,
  output logic              o_burst_start,
  output logic              o_burst_stop,
  output logic [ADDR_W-1:0] o_burst_addr
);
  // ****************
  // Request drivers
  // ****************
  // Idle values at time zero
  initial begin
    o_cmd_valid   = 1'b0;
    o_cmd_code    = flk_pkg::FLK_CMD_NONE;
    o_cmd_block   = '0;
    o_cmd_data    = 16'h0000;
    o_op_start    = 1'b0;
    o_op_kind     = flk_pkg::FLK_OP_ERASE;
    o_op_block    = '0;
    o_burst_start = 1'b0;
    o_burst_stop  = 1'b0;
    o_burst_addr  = '0;
  end

  // Released block and data are inverted so a stale value never passes for a fresh one
  task automatic cmd(input flk_pkg::flk_cmd_t c, input logic [BLK_W-1:0] b,
                     input logic [15:0] d);
    @(posedge i_clock);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd_code  = c;
    o_cmd_block = b;
    o_cmd_data  = d;
    @(posedge i_clock);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_block = ~b;
    o_cmd_data  = ~d;
  endtask

  // One-cycle operation start
  task automatic op(input flk_pkg::flk_op_t k, input logic [BLK_W-1:0] b);
    @(posedge i_clock);
    #1;
    o_op_start = 1'b1;
    o_op_kind  = k;
    o_op_block = b;
    @(posedge i_clock);
    #1;
    o_op_start = 1'b0;
    o_op_block = ~b;
  endtask

  // One-cycle burst start with its word address
  task automatic burst(input logic [ADDR_W-1:0] a);
    @(posedge i_clock);
    #1;
    o_burst_start = 1'b1;
    o_burst_addr  = a;
    @(posedge i_clock);
    #1;
    o_burst_start = 1'b0;
    o_burst_addr  = ~a;
  endtask

  // Ends a continuous burst
  task automatic stop;
    @(posedge i_clock);
    #1;
    o_burst_stop = 1'b1;
    @(posedge i_clock);
    #1;
    o_burst_stop = 1'b0;
  endtask

  // Only the three supported latency codes are ever chosen
  function automatic logic [2:0] lat_code(input logic [1:0] r);
    lat_code = 3'h2 + {1'b0, r % 2'h3};
  endfunction

  // Upper status byte is reserved and ignored when polling
  function automatic logic [15:0] masked(input logic [15:0] s);
    masked = s & 16'h00FF;
  endfunction
endmodule // flk_host

// File: dv/test_flash_lock_status_burst_config.sv
// Self-checking bench for the lock, status and read configuration block.
// Assumes flk_pkg, flk_defs.svh and the host model are compiled first.
`timescale 1ns/1ps

module test_flash_lock_status_burst_config;
  localparam int OPC = 4;
  logic              clk, rstn, wpn, sok, esus, psus, obusy, fmode;
  logic              cv, os, bs, bp, bv, wt;
  flk_pkg::flk_cmd_t cc;
  flk_pkg::flk_op_t  okd;
  logic [2:0]        cb, ob, idb;
  logic [15:0]       cd, st, bst, rc, cfg, sticky;
  logic [1:0]        lf;
  logic [21:0]       ba, bad;
  logic [21:0]       q[$];
  logic [21:0]       got[$];
  logic [31:0]       r;
  logic [31:0]       seed = 32'hA1E20066;
  int                n_fail = 0;
  int                total_checks = 0;
  int                ld[8], lk[8], p110[8];
  int                n, h, len, s, a, acc, b, k, cnt;
  bit                wp;

  flk_host i_host (.i_clock(clk), .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_block(cb),
    .o_cmd_data(cd), .o_op_start(os), .o_op_kind(okd), .o_op_block(ob), .o_burst_start(bs),
    .o_burst_stop(bp), .o_burst_addr(ba));

  flk_core #(.OP_CYCLES(OPC)) i_dut (.i_clock(clk), .i_resetn(rstn), .i_write_protect_n(wpn),
    .i_cmd_valid(cv), .i_cmd_code(cc), .i_cmd_block(cb), .i_cmd_data(cd), .i_op_start(os),
    .i_op_kind(okd), .i_op_block(ob), .i_supply_ok(sok), .i_erase_suspend(esus),
    .i_program_suspend(psus), .i_other_busy(obusy), .i_factory_mode(fmode),
    .i_id_block(idb), .i_burst_start(bs), .i_burst_stop(bp), .i_burst_addr(ba),
    .o_status(st), .o_buffer_status(bst), .o_read_config(rc), .o_lock_flags(lf),
    .o_burst_addr(bad), .o_burst_valid(bv), .o_wait(wt));

  // ****************
  // Helpers
  // ****************
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic report_and_stop;
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_addr(input logic [21:0] g, input logic [21:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Stimulus always lands 1 ns after the edge, clear of the sampling race
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      ld[i] = 0;
      lk[i] = 1;
      p110[i] = 0;
    end
    sticky = 16'h0000;
  endtask

  // Lock flags lag the block select by one cycle
  task automatic chk_locks;
    for (int i = 0; i < 8; i++) begin
      idb = i[2:0];
      cyc(2);
      chk_word({14'h0000, lf}, {14'h0000, ld[i] != 0, lk[i] != 0});
    end
  endtask

  // Reference lock table for commands with protect steady
  function automatic void lock_cmd(input int c, input int i);
    if (ld[i] != 0 && !wp) return;
    if (c == 3) begin
      ld[i] = 1;
      lk[i] = 1;
      p110[i] = 0;
    end else lk[i] = (c == 1);
  endfunction

  // Protect pin edge; falling edge remembers which lock-down state it left
  task automatic wp_edge;
    cyc(1);
    wpn = ~wpn;
    for (int i = 0; i < 8; i++) begin
      if (wp) begin
        p110[i] = (ld[i] != 0 && lk[i] == 0);
        if (ld[i] != 0) lk[i] = 1;
      end else if (ld[i] != 0) lk[i] = (p110[i] == 0);
    end
    wp = ~wp;
  endtask

  function automatic logic [15:0] exp_st(input bit busy);
    exp_st = sticky;
    exp_st[6] = esus;
    exp_st[2] = psus;
    exp_st[7] = !busy && !obusy && !fmode;
    exp_st[0] = fmode ? busy : (!busy && obusy);
  endfunction

  // ****************
  // Main sequence
  // ****************
  initial begin
    rstn = 1'b0;
    wpn = 1'b1;
    wp = 1'b1;
    {sok, esus, psus, obusy, fmode} = 5'h10;
    idb = 3'h0;
    do_reset;
    chk_word(st, 16'h0080);
    chk_word(bst, 16'h0080);
    chk_word(rc, 16'hFFFF);
    chk_locks;
    // Random walk over lock commands and protect edges
    for (int i = 0; i < 120; i++) begin
      r = rnd();
      if (r[1:0] == 2'h0) wp_edge;
      else begin
        i_host.cmd(flk_pkg::flk_cmd_t'({1'b0, r[1:0]}), r[4:2], r[31:16]);
        lock_cmd(r[1:0], r[4:2]);
      end
      if (i % 4 == 3) chk_locks;
    end
    // Operations on whatever lock states the walk left
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      b = r[6:4];
      k = i % 4;
      sok = (r[3:2] != 2'h0);
      esus = r[7];
      psus = r[8];
      acc = sok && !(lk[b] != 0 && k != 3);
      if (!sok) sticky[3] = 1'b1;
      else if (acc == 0) sticky[1] = 1'b1;
      if (acc == 0) sticky[(k == 0) ? 5 : 4] = 1'b1;
      i_host.op(flk_pkg::flk_op_t'(k[1:0]), b[2:0]);
      cyc(2);
      chk_word(i_host.masked(st), i_host.masked(exp_st(acc != 0)));
      chk_word(bst, (acc != 0) ? 16'h0000 : 16'h0080);
      cyc(OPC + 1);
      chk_word(st, exp_st(1'b0));
      if (i % 4 == 3) begin
        obusy = 1'b1;
        i_host.cmd(flk_pkg::FLK_CMD_CLR_STAT, 3'h0, 16'h0000);
        sticky = 16'h0000;
        cyc(2);
        chk_word(st, exp_st(1'b0));
        obusy = 1'b0;
      end
    end
    // Factory program mode: busy shows as 01, done as 00
    fmode = 1'b1;
    sok = 1'b1;
    i_host.op(flk_pkg::FLK_OP_OTP, 3'h0);
    cyc(2);
    chk_word(st, exp_st(1'b1));
    cyc(OPC + 1);
    chk_word(st, exp_st(1'b0));
    fmode = 1'b0;
    // Bursts over length codes 1, 2 and 7, every order and wrap setting
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      len = (i % 3 == 0) ? 1 : (i % 3 == 1) ? 2 : 7;
      n = (len == 1) ? 4 : (len == 2) ? 8 : 0;
      cfg = {2'h1, i_host.lat_code(r[1:0]), r[2], r[3], 1'b1, ((i / 3) % 2) == 1, 3'h7,
             i >= 6, len[2:0]};
      i_host.cmd(flk_pkg::FLK_CMD_SET_RCFG, 3'h0, cfg);
      cyc(2);
      chk_word(rc, cfg);
      chk_word({15'h0000, wt}, {15'h0000, ~cfg[10]});
      s = r[25:10];
      h = cfg[9] ? 2 : 1;
      q.delete();
      got.delete();
      for (int j = 0; j < ((n == 0) ? 8 : n); j++) begin
        if (n == 0 || (cfg[7] && cfg[3])) a = s + j;
        else if (cfg[7]) a = (s & ~(n - 1)) | ((s + j) & (n - 1));
        else a = (s & ~(n - 1)) | ((s ^ j) & (n - 1));
        repeat (h) q.push_back(a[21:0]);
      end
      i_host.burst(s[21:0]);
      for (int c = 1; c <= 60 && got.size() < q.size(); c++) begin
        cyc(1);
        if (c == 2) chk_word({15'h0000, wt}, {15'h0000, cfg[10]});
        if (bv === 1'b1) got.push_back(bad);
      end
      if (n == 0) i_host.stop();
      else begin
        cyc(2);
        chk_word({15'h0000, bv}, 16'h0000);
      end
      if (got.size() != q.size()) begin
        n_fail++;
        report_and_stop;
      end
      foreach (q[j]) chk_addr(got[j], q[j]);
    end
    // Asynchronous mode ignores a burst request
    i_host.cmd(flk_pkg::FLK_CMD_SET_RCFG, 3'h0, 16'hFFFF);
    i_host.burst(22'h000005);
    cnt = 0;
    for (int c = 0; c < 12; c++) begin
      cyc(1);
      if (bv !== 1'b0) cnt++;
    end
    chk_word(cnt[15:0], 16'h0000);
    // Second reset after configuration and lock changes
    i_host.cmd(flk_pkg::FLK_CMD_SET_RCFG, 3'h0, 16'h1234);
    do_reset;
    chk_word(rc, 16'hFFFF);
    chk_word(st, 16'h0080);
    chk_locks;
    report_and_stop;
  end
endmodule // test_flash_lock_status_burst_config
